// [logic/bias_cfg_pkg.sv]
`default_nettype none
package bias_cfg_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MISC_CONFIGURATION = 8'h00;
  localparam logic [7:0] OFS_BOOST_ONE_VOLTAGE = 8'h01;
  localparam logic [7:0] OFS_GAMMA_M_HIGH_BITS = 8'h24;
  localparam logic [7:0] OFS_GAMMA_M_LOW_BITS = 8'h25;
  localparam logic [7:0] OFS_GAMMA_N_HIGH_BITS = 8'h26;
  localparam logic [7:0] OFS_GAMMA_N_LOW_BITS = 8'h27;
  localparam logic [7:0] OFS_STORAGE_SELECT = 8'hFF;

  // ---------------------------------------------------------------
  // Factory defaults
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MISC_CONFIGURATION = 8'h00;
  localparam logic [7:0] RST_BOOST_ONE_VOLTAGE = 8'h0E;
  localparam logic [7:0] RST_GAMMA_HIGH_BITS = 8'h02;
  localparam logic [7:0] RST_GAMMA_LOW_BITS = 8'h00;
  localparam logic [7:0] RST_STORAGE_SELECT = 8'h00;

  // ---------------------------------------------------------------
  // Implemented-bit masks; other bits drop writes and read zero
  // ---------------------------------------------------------------
  localparam logic [7:0] MSK_MISC_CONFIGURATION = 8'h07;
  localparam logic [7:0] MSK_BOOST_ONE_VOLTAGE = 8'h1F;
  localparam logic [7:0] MSK_GAMMA_HIGH_BITS = 8'h03;
  localparam logic [7:0] MSK_GAMMA_LOW_BITS = 8'hFF;
  localparam logic [7:0] MSK_STORAGE_SELECT = 8'h01;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_RESET_THRESHOLD_SELECT = 2;
  localparam int POS_DISCHARGE_TARGET_SELECT = 1;
  localparam int POS_GATE_IN_PANEL_MODE = 0;
  localparam int POS_USE_NONVOLATILE = 0;

  // Banked entries, in order: config, boost, m hi, m lo, n hi, n lo
  localparam int NUM_BANKED = 6;
  localparam logic [7:0] I2C_ADDR_DEFAULT = 8'h4E; // Arbitrary value
endpackage : bias_cfg_pkg
`default_nettype wire

// [logic/pin_sync_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Filtered pin levels handed from the synchroniser to the register bank
interface pin_sync_if;
  logic scl;
  logic sda;
  logic write_protect;
  logic power_down;
  modport src (output scl, output sda, output write_protect,
               output power_down);
  modport dst (input scl, input sda, input write_protect,
               input power_down);
endinterface : pin_sync_if
`default_nettype wire

// [logic/pin_filter.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_filter #(
  parameter logic [3:0] RESET_LEVELS = 4'h7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] pins,
  pin_sync_if.src levels
);
  logic [3:0] flt_r;

  // ---------------------------------------------------------------
  // Three stages per pin; level moves only when stages 2 and 3 agree
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_pin
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // Stage 1 feeds stage 2 only, keeping metastability contained
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_r <= RESET_LEVELS[i];
        s2_r <= RESET_LEVELS[i];
        s3_r <= RESET_LEVELS[i];
        flt_r[i] <= RESET_LEVELS[i];
      end else begin
        s1_r <= pins[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          flt_r[i] <= s3_r;
        end
      end
    end
  end

  assign levels.scl = flt_r[0];
  assign levels.sda = flt_r[1];
  assign levels.write_protect = flt_r[2];
  assign levels.power_down = flt_r[3];
endmodule // pin_filter
`default_nettype wire

// [logic/lcd_bias_config_registers.sv]
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Gamma M is 10 bits: high two bits at 24h default 02h, low at 25h.
// - Gamma N is 10 bits: high two bits at 26h default 02h, low at 27h.
// - Register at FFh picks volatile or nonvolatile copy for accesses.
// - Bits without hardware ignore writes and read back zero.
// - Config bit 2 picks lockout or detection threshold for reset.
// - Config bit 1 picks boost rail or common voltage for discharge.
// - Config bit 0 picks non gate-in-panel or gate-in-panel panels.
// - Discharge pin is panel reset, or shifter enable in gate-in-panel mode.
// - Boost one voltage is a 5-bit code, default 0Eh.
module lcd_bias_config_registers #(
  parameter logic [6:0] DEVICE_ADDR = bias_cfg_pkg::I2C_ADDR_DEFAULT[7:1]
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  input wire logic power_down,
  output logic reset_threshold_select,
  output logic boost_rail_discharge_en,
  output logic common_voltage_discharge_en,
  output logic gate_in_panel_mode,
  output logic panel_discharge_output_n,
  output logic [4:0] boost_one_voltage_code,
  output logic [9:0] gamma_m_code,
  output logic [9:0] gamma_n_code
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_RX_ACK = 3'h6,
    ST_TX = 3'h7,
    ST_TX_ACK = 3'h5
  } bus_state_e;

  typedef logic [7:0] byte_t;

  // Per-entry defaults and masks of the banked registers
  localparam byte_t DEF_TAB [bias_cfg_pkg::NUM_BANKED] = '{
    bias_cfg_pkg::RST_MISC_CONFIGURATION, bias_cfg_pkg::RST_BOOST_ONE_VOLTAGE,
    bias_cfg_pkg::RST_GAMMA_HIGH_BITS, bias_cfg_pkg::RST_GAMMA_LOW_BITS,
    bias_cfg_pkg::RST_GAMMA_HIGH_BITS, bias_cfg_pkg::RST_GAMMA_LOW_BITS};
  localparam byte_t MSK_TAB [bias_cfg_pkg::NUM_BANKED] = '{
    bias_cfg_pkg::MSK_MISC_CONFIGURATION, bias_cfg_pkg::MSK_BOOST_ONE_VOLTAGE,
    bias_cfg_pkg::MSK_GAMMA_HIGH_BITS, bias_cfg_pkg::MSK_GAMMA_LOW_BITS,
    bias_cfg_pkg::MSK_GAMMA_HIGH_BITS, bias_cfg_pkg::MSK_GAMMA_LOW_BITS};

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Async assert, release after two edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin filtering and bus edge detection
  // ---------------------------------------------------------------
  pin_sync_if pins_if ();

  // Write protect idles high, standing in for its internal pull-up
  pin_filter #(.RESET_LEVELS(4'h7)) u_pin_filter (
    .sys_clk(sys_clk),
    .rst_n(rst_n_r),
    .pins({power_down, write_protect, sda_in, scl}),
    .levels(pins_if)
  );

  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Previous filtered levels for edge detection
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= pins_if.scl;
      sda_d_r <= pins_if.sda;
    end
  end

  assign scl_rise = pins_if.scl & ~scl_d_r;
  assign scl_fall = ~pins_if.scl & scl_d_r;
  assign start_seen = pins_if.scl & scl_d_r & sda_d_r & ~pins_if.sda;
  assign stop_seen = pins_if.scl & scl_d_r & ~sda_d_r & pins_if.sda;

  // ---------------------------------------------------------------
  // Register storage: a volatile and a nonvolatile copy
  // ---------------------------------------------------------------
  byte_t ram_r [bias_cfg_pkg::NUM_BANKED];
  byte_t nv_r [bias_cfg_pkg::NUM_BANKED];
  byte_t select_r;
  logic [7:0] ptr_r;
  logic wr_en;
  byte_t wr_data;
  logic [2:0] hit_idx;
  logic hit;
  byte_t rd_data;
  logic use_nv;

  assign use_nv = select_r[bias_cfg_pkg::POS_USE_NONVOLATILE];

  // Address decode of the banked entries
  always_comb begin
    hit = 1'b1;
    hit_idx = 3'h0;
    if (ptr_r == bias_cfg_pkg::OFS_MISC_CONFIGURATION) begin
      hit_idx = 3'h0;
    end else if (ptr_r == bias_cfg_pkg::OFS_BOOST_ONE_VOLTAGE) begin
      hit_idx = 3'h1;
    end else if (ptr_r == bias_cfg_pkg::OFS_GAMMA_M_HIGH_BITS) begin
      hit_idx = 3'h2;
    end else if (ptr_r == bias_cfg_pkg::OFS_GAMMA_M_LOW_BITS) begin
      hit_idx = 3'h3;
    end else if (ptr_r == bias_cfg_pkg::OFS_GAMMA_N_HIGH_BITS) begin
      hit_idx = 3'h4;
    end else if (ptr_r == bias_cfg_pkg::OFS_GAMMA_N_LOW_BITS) begin
      hit_idx = 3'h5;
    end else begin
      hit = 1'b0;
    end
  end

  // Read mux; unmapped offsets and missing bits read zero
  always_comb begin
    rd_data = 8'h00;
    if (hit) begin
      rd_data = use_nv ? nv_r[hit_idx] : ram_r[hit_idx];
    end else if (ptr_r == bias_cfg_pkg::OFS_STORAGE_SELECT) begin
      rd_data = select_r;
    end
  end

  // One process per entry; writes keep only implemented bits
  for (genvar e = 0; e < bias_cfg_pkg::NUM_BANKED; e++) begin : g_entry
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        ram_r[e] <= DEF_TAB[e];
        nv_r[e] <= DEF_TAB[e];
      end else if (wr_en && hit && hit_idx == 3'(e)) begin
        if (use_nv) begin
          nv_r[e] <= wr_data & MSK_TAB[e];
        end else begin
          ram_r[e] <= wr_data & MSK_TAB[e];
        end
      end
    end
  end

  // Storage select is itself never banked
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      select_r <= bias_cfg_pkg::RST_STORAGE_SELECT;
    end else if (wr_en && ptr_r == bias_cfg_pkg::OFS_STORAGE_SELECT) begin
      select_r <= wr_data & bias_cfg_pkg::MSK_STORAGE_SELECT;
    end
  end

  // ---------------------------------------------------------------
  // Serial bus target
  // ---------------------------------------------------------------
  bus_state_e state_r;
  logic [2:0] bit_cnt_r;
  logic full_r;
  byte_t shift_r;
  byte_t tx_r;
  logic read_r;
  logic first_r;
  logic nack_r;
  logic sda_oe_r;

  assign wr_en = (state_r == ST_RX) && scl_fall && full_r && !first_r;
  assign wr_data = shift_r;

  // Protocol engine; write protect aborts and silences everything
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      full_r <= 1'b0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      read_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      ptr_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (pins_if.write_protect) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_seen) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'h0;
      full_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_seen) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      // Data is taken while the clock is high
      shift_r <= {shift_r[6:0], pins_if.sda};
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (state_r != ST_ADDR_ACK && state_r != ST_RX_ACK
          && state_r != ST_TX_ACK) begin
        full_r <= (bit_cnt_r == 3'h7);
      end
      nack_r <= pins_if.sda;
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: begin
          if (full_r) begin
            full_r <= 1'b0;
            if (shift_r[7:1] == DEVICE_ADDR) begin
              state_r <= ST_ADDR_ACK;
              read_r <= shift_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt_r <= 3'h0;
          first_r <= 1'b1;
          if (read_r) begin
            state_r <= ST_TX;
            tx_r <= rd_data;
            sda_oe_r <= ~rd_data[7];
            ptr_r <= ptr_r + 8'h01;
          end else begin
            state_r <= ST_RX;
            sda_oe_r <= 1'b0;
          end
        end
        ST_RX: begin
          if (full_r) begin
            full_r <= 1'b0;
            state_r <= ST_RX_ACK;
            sda_oe_r <= 1'b1;
            first_r <= 1'b0;
            // First byte sets the pointer, later bytes write and advance
            ptr_r <= first_r ? shift_r : ptr_r + 8'h01;
          end
        end
        ST_RX_ACK: begin
          state_r <= ST_RX;
          bit_cnt_r <= 3'h0;
          sda_oe_r <= 1'b0;
        end
        ST_TX: begin
          if (full_r) begin
            full_r <= 1'b0;
            state_r <= ST_TX_ACK;
            sda_oe_r <= 1'b0;
          end else begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        ST_TX_ACK: begin
          bit_cnt_r <= 3'h0;
          // A refusal from the host ends the read; wait for stop
          if (nack_r) begin
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_TX;
            tx_r <= rd_data;
            sda_oe_r <= ~rd_data[7];
            ptr_r <= ptr_r + 8'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs, registered; the volatile copy runs the hardware
  // ---------------------------------------------------------------
  logic gate_mode;
  logic pd;

  assign gate_mode = ram_r[0][bias_cfg_pkg::POS_GATE_IN_PANEL_MODE];
  assign pd = pins_if.power_down;

  // Open drain: line is only ever pulled low
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= sda_oe_r;
    end
  end

  // Threshold from config bit 2; power-down steering of discharge and panel pin
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reset_threshold_select <= 1'b0;
      boost_rail_discharge_en <= 1'b0;
      common_voltage_discharge_en <= 1'b0;
      gate_in_panel_mode <= 1'b0;
      panel_discharge_output_n <= 1'b1;
    end else begin
      reset_threshold_select <=
        ram_r[0][bias_cfg_pkg::POS_RESET_THRESHOLD_SELECT];
      boost_rail_discharge_en <= pd &
        ~ram_r[0][bias_cfg_pkg::POS_DISCHARGE_TARGET_SELECT];
      common_voltage_discharge_en <= pd &
        ram_r[0][bias_cfg_pkg::POS_DISCHARGE_TARGET_SELECT];
      gate_in_panel_mode <= gate_mode;
      // Reset pulls low in power-down; enable pulls low while running
      panel_discharge_output_n <= gate_mode ? pd : ~pd;
    end
  end

  // Code words handed to the converters and gamma buffers
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      boost_one_voltage_code <= bias_cfg_pkg::RST_BOOST_ONE_VOLTAGE[4:0];
      gamma_m_code <= {bias_cfg_pkg::RST_GAMMA_HIGH_BITS[1:0],
                       bias_cfg_pkg::RST_GAMMA_LOW_BITS};
      gamma_n_code <= {bias_cfg_pkg::RST_GAMMA_HIGH_BITS[1:0],
                       bias_cfg_pkg::RST_GAMMA_LOW_BITS};
    end else begin
      boost_one_voltage_code <= ram_r[1][4:0];
      gamma_m_code <= {ram_r[2][1:0], ram_r[3]};
      gamma_n_code <= {ram_r[4][1:0], ram_r[5]};
    end
  end
endmodule // lcd_bias_config_registers
`default_nettype wire

// [bench/bias_cfg_props.sv]
`timescale 1ns/100ps
`default_nettype none
module bias_cfg_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic write_protect,
  input wire logic power_down,
  input wire logic boost_rail_discharge_en,
  input wire logic common_voltage_discharge_en,
  input wire logic gate_in_panel_mode,
  input wire logic panel_discharge_output_n,
  input wire logic [4:0] boost_one_voltage_code,
  input wire logic [9:0] gamma_m_code,
  input wire logic [9:0] gamma_n_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // -------------------------------------------------------------
  // Settled spans; eight cycles cover filter plus output register
  // -------------------------------------------------------------
  sequence pd_on;
    (power_down && $stable(gate_in_panel_mode)) [*8];
  endsequence
  sequence pd_off;
    (!power_down && $stable(gate_in_panel_mode)) [*8];
  endsequence
  sequence wp_on;
    write_protect [*8];
  endsequence
  // Six only: each host bus phase lasts just seven cycles
  sequence bus_idle;
    (scl && sda_in) [*6];
  endsequence
  chk_rail_quiet: assert property (
    pd_off |=> !(boost_rail_discharge_en || common_voltage_discharge_en))
    else $error("rail discharge without power down");
  chk_rail_single: assert property (
    power_down [*8] |=>
    boost_rail_discharge_en ^ common_voltage_discharge_en)
    else $error("not exactly one rail discharged");
  chk_rail_exclusive: assert property (
    !(boost_rail_discharge_en && common_voltage_discharge_en))
    else $error("both rails discharged");
  chk_panel_down: assert property (
    pd_on |=> panel_discharge_output_n == gate_in_panel_mode)
    else $error("panel pin wrong during power down");
  chk_panel_run: assert property (
    pd_off |=> panel_discharge_output_n != gate_in_panel_mode)
    else $error("panel pin wrong while running");
  chk_wp_silent: assert property (wp_on |=> !sda_oe)
    else $error("bus driven while write protected");
  chk_wp_frozen: assert property (wp_on |=>
    $stable(gamma_m_code) && $stable(gamma_n_code)
    && $stable(boost_one_voltage_code))
    else $error("code changed while write protected");
  chk_idle_frozen: assert property (bus_idle |=>
    $stable({gamma_m_code, gamma_n_code, boost_one_voltage_code}))
    else $error("code changed on idle bus");
  chk_ack_wp_low: assert property (
    $rose(sda_oe) |-> !write_protect && !scl)
    else $error("bus answer with protect high or clock high");
  // Open drain: the data pin may only ever be pulled low
  chk_sda_low: assert property (!sda_out)
    else $error("data line driven high");
endmodule // bias_cfg_props
bind lcd_bias_config_registers bias_cfg_props u_props (
  .sys_clk, .reset_n, .scl, .sda_in, .sda_oe, .sda_out, .write_protect,
  .power_down, .boost_rail_discharge_en, .common_voltage_discharge_en,
  .gate_in_panel_mode, .panel_discharge_output_n,
  .boost_one_voltage_code, .gamma_m_code, .gamma_n_code);
`default_nettype wire

// [bench/bias_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bias_host_model #(
  parameter logic [6:0] ADDR = 7'h27
) (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in,
  output logic write_protect
);
  logic pull_r;
  // Open-drain wire with pull-up: low if either side pulls
  assign sda_in = !(pull_r || sda_oe);
  // Pin pulled high until the host takes it low
  initial begin
    scl = 1'b1;
    pull_r = 1'b0;
    write_protect = 1'b1;
  end
  // -------------------------------------------------------------
  // Bus phases; seven cycles each, filter needs at least four
  // -------------------------------------------------------------
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic set_wp(input logic v);
    @(posedge sys_clk) write_protect <= v;
    half();
  endtask
  // Data moves mid low phase, never at a clock edge of the bus
  task automatic clk_bit(input logic d, output logic s);
    @(posedge sys_clk) pull_r <= !d;
    half();
    @(posedge sys_clk) scl <= 1'b1;
    half();
    s = sda_in;
    @(posedge sys_clk) scl <= 1'b0;
    half();
  endtask
  task automatic start();
    @(posedge sys_clk) pull_r <= 1'b0;
    half();
    @(posedge sys_clk) scl <= 1'b1;
    half();
    @(posedge sys_clk) pull_r <= 1'b1;
    half();
    @(posedge sys_clk) scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    @(posedge sys_clk) pull_r <= 1'b1;
    half();
    @(posedge sys_clk) scl <= 1'b1;
    half();
    @(posedge sys_clk) pull_r <= 1'b0;
    half();
  endtask
  // Byte MSB first, ninth bit level lvl, ack seen as low
  task automatic xfer(input logic [7:0] tx, input logic lvl,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(lvl, ack);
    ack = !ack;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    xfer(d, 1'b1, rx, a2);
    stop();
    ok = a0 && a1 && a2;
  endtask
  // Pointer write, repeated start, one byte then host refusal
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule // bias_host_model
`default_nettype wire

// [bench/lcd_bias_config_registers_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module lcd_bias_config_registers_bench;
  localparam logic [7:0] OFS [7] = '{8'h00, 8'h01, 8'h24, 8'h25,
                                     8'h26, 8'h27, 8'hFF};
  localparam logic [7:0] DEF [7] = '{8'h00, 8'h0E, 8'h02, 8'h00,
                                     8'h02, 8'h00, 8'h00};
  localparam logic [7:0] MSK [6] = '{8'h07, 8'h1F, 8'h03, 8'hFF,
                                     8'h03, 8'hFF};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_down = 1'b0;
  logic scl, sda_in, sda_out, sda_oe, write_protect;
  logic reset_threshold_select, boost_rail_discharge_en, gate_in_panel_mode;
  logic common_voltage_discharge_en, panel_discharge_output_n;
  logic [4:0] boost_one_voltage_code;
  logic [9:0] gamma_m_code, gamma_n_code;
  int fail_count = 0;
  int samples_checked = 0;
  // 25 MHz
  always #20 sys_clk = !sys_clk;
  lcd_bias_config_registers #(.DEVICE_ADDR(7'h27)) u_dut (
    .sys_clk, .reset_n, .scl, .sda_in, .sda_out, .sda_oe,
    .write_protect, .power_down, .reset_threshold_select,
    .boost_rail_discharge_en, .common_voltage_discharge_en,
    .gate_in_panel_mode, .panel_discharge_output_n,
    .boost_one_voltage_code, .gamma_m_code, .gamma_n_code);
  bias_host_model #(.ADDR(7'h27)) u_host (
    .sys_clk, .sda_oe, .scl, .sda_in, .write_protect);
  // -------------------------------------------------------------
  // Access and compare helpers
  // -------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d,
                    input logic ok_exp);
    logic ok;
    u_host.write_reg(o, d, ok);
    check({15'h0000, ok}, {15'h0000, ok_exp});
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_host.read_reg(o, d, ok);
    check({7'h00, ok, d}, {8'h01, e});
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short; the run needs about 31000 cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    u_host.set_wp(1'b0);
    check({6'h00, gamma_m_code}, 16'h0200);
    check({6'h00, gamma_n_code}, 16'h0200);
    check({11'h000, boost_one_voltage_code}, 16'h000E);
    for (int i = 0; i < 7; i++) rd(OFS[i], DEF[i]);
    // All ones: unbacked bits drop, upper code boundary
    for (int i = 0; i < 6; i++) wr(OFS[i], 8'hFF, 1'b1);
    for (int i = 0; i < 6; i++) rd(OFS[i], MSK[i]);
    check({6'h00, gamma_m_code}, 16'h03FF);
    check({6'h00, gamma_n_code}, 16'h03FF);
    check({11'h000, boost_one_voltage_code}, 16'h001F);
    wr(8'h01, 8'h00, 1'b1);
    check({11'h000, boost_one_voltage_code}, 16'h0000);
    wr(8'h24, 8'h01, 1'b1);
    wr(8'h25, 8'hAB, 1'b1);
    check({6'h00, gamma_m_code}, 16'h01AB);
    wr(8'h27, 8'h5C, 1'b1);
    check({6'h00, gamma_n_code}, 16'h035C);
    // Every config code, with and without power down
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c), 1'b1);
      for (int p = 0; p < 2; p++) begin
        @(posedge sys_clk) power_down <= p[0];
        repeat (12) @(posedge sys_clk);
        check({11'h000, reset_threshold_select, gate_in_panel_mode,
               boost_rail_discharge_en, common_voltage_discharge_en,
               panel_discharge_output_n},
              {11'h000, c[2], c[0], p[0] & !c[1], p[0] & c[1],
               !(c[0] ^ p[0])});
      end
    end
    // Nonvolatile copy: own defaults, pins keep the RAM copy
    wr(8'hFF, 8'hFF, 1'b1);
    rd(8'hFF, 8'h01);
    rd(8'h25, 8'h00);
    wr(8'h01, 8'h15, 1'b1);
    rd(8'h01, 8'h15);
    check({11'h000, boost_one_voltage_code}, 16'h0000);
    wr(8'hFF, 8'h00, 1'b1);
    rd(8'h01, 8'h00);
    rd(8'h25, 8'hAB);
    // Protected bus is ignored; unmapped place reads zero
    u_host.set_wp(1'b1);
    wr(8'h25, 8'h55, 1'b0);
    u_host.set_wp(1'b0);
    rd(8'h25, 8'hAB);
    wr(8'h30, 8'h77, 1'b1);
    rd(8'h30, 8'h00);
    final_report();
  end
endmodule // lcd_bias_config_registers_bench
`default_nettype wire
